// ==== hdl/vcs_sequencer.sv ====
// Purpose: vco autocalibration timing sequencer with its reference path
// Assumes: counts are stable while cal_start is given; they are latched then
// Notes: every phase counts comparison-clock ticks, never raw mclk cycles
`default_nettype none
// Functional notes
// RL1 - doubler doubles reference frequency
// RL2 - halver divides reference, even duty
// RL3 - settle lasts timeout times lock-timeout ticks
// RL4 - host keeps settle at least 20 us
// RL5 - band clock is comparison over 16N
// RL6 - band selection lasts eleven band periods
// RL7 - level phase lasts 30 wait timeout
// RL8 - wait and lock-timeout are five bits
// RL9 - host sets wait near 2.5 lock-timeout
// RL10 - phases run strictly in order
module vcs_sequencer (
   input wire logic mclk,
   input wire logic srst,
   input wire logic ref_in,
   input wire logic doubler_en,
   input wire logic halve_en,
   input wire logic cal_start,
   input wire vcs_pkg::vcs_cfg_s cfg_in,
   output logic pfd_clk,
   output logic band_clk,
   output logic tuning_voltage_hold,
   output logic band_select_active,
   output logic automatic_level_calibration_active,
   output logic cal_busy,
   output logic cal_done
);
   // RL8 - five-bit count fields
   if (vcs_pkg::LEVEL_W != 5) begin : g_bad_width
      $error("count fields must be five bits");
   end

   // zero-length product is served as one tick, so the sequence always ends
   function automatic vcs_pkg::vcs_cnt_t last_tick(input vcs_pkg::vcs_cnt_t len);
      last_tick = (len == vcs_pkg::CNT_RESET) ? vcs_pkg::CNT_RESET : len - 1'b1;
   endfunction

   logic pfd_tick;
   logic pfd_clk_int;
   vcs_pkg::vcs_state_e state;
   vcs_pkg::vcs_state_e next_state;
   vcs_pkg::vcs_cfg_s cfg;
   vcs_pkg::vcs_cfg_s next_cfg;
   vcs_pkg::vcs_cnt_t cnt;
   vcs_pkg::vcs_cnt_t next_cnt;
   vcs_pkg::vcs_bcnt_t bcnt;
   vcs_pkg::vcs_bcnt_t next_bcnt;
   logic [vcs_pkg::BAND_PER_W-1:0] bper;
   logic [vcs_pkg::BAND_PER_W-1:0] next_bper;
   vcs_pkg::vcs_cnt_t settle_last;
   vcs_pkg::vcs_cnt_t level_last;
   vcs_pkg::vcs_bcnt_t band_len;
   vcs_pkg::vcs_bcnt_t band_last;
   logic next_band_clk;
   logic next_cal_done;
   logic next_pfd_clk;

   vcs_ref_path u_ref (
      .mclk(mclk),
      .srst(srst),
      .ref_in(ref_in),
      .doubler_en(doubler_en),
      .halve_en(halve_en),
      .pfd_tick(pfd_tick),
      .pfd_clk(pfd_clk_int)
   );

   // phase lengths from the latched counts
   always_comb begin
      // RL3 - settle length product
      settle_last = last_tick(vcs_pkg::vcs_cnt_t'(cfg.timeout) * vcs_pkg::vcs_cnt_t'(cfg.lock_timeout));
      // RL7 - level length product
      level_last = last_tick(vcs_pkg::LEVEL_FACTOR * vcs_pkg::vcs_cnt_t'(cfg.level_wait)
                             * vcs_pkg::vcs_cnt_t'(cfg.timeout));
      // RL5 - divide by sixteen N
      band_len = vcs_pkg::BAND_DIV_FACTOR * vcs_pkg::vcs_bcnt_t'(cfg.band_div);
      band_last = (band_len == vcs_pkg::BAND_CNT_RESET) ? vcs_pkg::BAND_CNT_RESET : band_len - 1'b1;
   end

   // phase sequencing; a start while busy is ignored
   always_comb begin
      next_state = state;
      next_cfg = cfg;
      next_cnt = cnt;
      next_bcnt = bcnt;
      next_bper = bper;
      next_cal_done = 1'b0;
      next_pfd_clk = pfd_clk_int;
      next_band_clk = 1'b0;
      unique case (state)
         vcs_pkg::ST_IDLE: begin
            if (cal_start) begin
               next_cfg = cfg_in;
               next_cnt = vcs_pkg::CNT_RESET;
               next_state = vcs_pkg::ST_SETTLE;
            end
         end
         vcs_pkg::ST_SETTLE: begin
            if (pfd_tick) begin
               // RL10 - band only after settle
               if (cnt >= settle_last) begin
                  next_cnt = vcs_pkg::CNT_RESET;
                  next_bcnt = vcs_pkg::BAND_CNT_RESET;
                  next_bper = vcs_pkg::BAND_PER_RESET;
                  next_state = vcs_pkg::ST_BAND;
               end else begin
                  next_cnt = cnt + 1'b1;
               end
            end
         end
         vcs_pkg::ST_BAND: begin
            // high for the first half of each band period
            next_band_clk = (bcnt < (band_len >> 1)) || (band_len == vcs_pkg::BAND_CNT_RESET);
            if (pfd_tick) begin
               if (bcnt >= band_last) begin
                  next_bcnt = vcs_pkg::BAND_CNT_RESET;
                  // RL6 - eleven band periods
                  if (bper == vcs_pkg::BAND_PERIODS - 1'b1) begin
                     next_bper = vcs_pkg::BAND_PER_RESET;
                     next_cnt = vcs_pkg::CNT_RESET;
                     next_band_clk = 1'b0;
                     // RL10 - level only after band
                     next_state = vcs_pkg::ST_LEVEL;
                  end else begin
                     next_bper = bper + 1'b1;
                  end
               end else begin
                  next_bcnt = bcnt + 1'b1;
               end
            end
         end
         vcs_pkg::ST_LEVEL: begin
            if (pfd_tick) begin
               if (cnt >= level_last) begin
                  next_cnt = vcs_pkg::CNT_RESET;
                  next_cal_done = 1'b1;
                  next_state = vcs_pkg::ST_IDLE;
               end else begin
                  next_cnt = cnt + 1'b1;
               end
            end
         end
         default: begin
            next_state = vcs_pkg::ST_IDLE;
         end
      endcase
   end

   // registers; status outputs decode the next state so they stay flop-driven
   always_ff @(posedge mclk) begin
      if (srst) begin
         state <= vcs_pkg::ST_IDLE;
         cfg <= vcs_pkg::CFG_RESET;
         cnt <= vcs_pkg::CNT_RESET;
         bcnt <= vcs_pkg::BAND_CNT_RESET;
         bper <= vcs_pkg::BAND_PER_RESET;
         pfd_clk <= 1'b0;
         band_clk <= 1'b0;
         tuning_voltage_hold <= 1'b0;
         band_select_active <= 1'b0;
         automatic_level_calibration_active <= 1'b0;
         cal_busy <= 1'b0;
         cal_done <= 1'b0;
      end else begin
         state <= next_state;
         cfg <= next_cfg;
         cnt <= next_cnt;
         bcnt <= next_bcnt;
         bper <= next_bper;
         pfd_clk <= next_pfd_clk;
         band_clk <= next_band_clk;
         tuning_voltage_hold <= (next_state == vcs_pkg::ST_SETTLE);
         band_select_active <= (next_state == vcs_pkg::ST_BAND);
         automatic_level_calibration_active <= (next_state == vcs_pkg::ST_LEVEL);
         cal_busy <= (next_state != vcs_pkg::ST_IDLE);
         cal_done <= next_cal_done;
      end
   end
endmodule
`default_nettype wire

// ==== hdl/vcs_pkg.sv ====
// Purpose: shared constants, types and states of the vco calibration sequencer
// Assumes: one clock (mclk); all counting runs on a comparison-clock enable
// Notes: count fields are carried in one packed struct
`default_nettype none
package vcs_pkg;
   localparam int LEVEL_W = 5;          // wait and lock-timeout field width
   localparam int TIMEOUT_W = 10;       // shared timeout count width
   localparam int BAND_W = 8;           // band-selection count width
   localparam int CNT_W = 20;           // holds 30 * 31 * 1023
   localparam int BAND_CNT_W = 12;      // holds 16 * 255
   localparam int BAND_PER_W = 4;       // holds 11
   localparam logic [4:0] LEVEL_MAX = 5'h1F;
   localparam logic [BAND_CNT_W-1:0] BAND_DIV_FACTOR = 12'h010;   // 16
   localparam logic [BAND_PER_W-1:0] BAND_PERIODS = 4'hB;         // 11
   localparam logic [CNT_W-1:0] LEVEL_FACTOR = 20'h0001E;         // 30
   localparam logic [CNT_W-1:0] CNT_RESET = 20'h00000;
   localparam logic [BAND_CNT_W-1:0] BAND_CNT_RESET = 12'h000;
   localparam logic [BAND_PER_W-1:0] BAND_PER_RESET = 4'h0;

   typedef logic [CNT_W-1:0] vcs_cnt_t;
   typedef logic [BAND_CNT_W-1:0] vcs_bcnt_t;

   typedef struct packed {
      logic [TIMEOUT_W-1:0] timeout;
      logic [LEVEL_W-1:0] lock_timeout;
      logic [BAND_W-1:0] band_div;
      logic [LEVEL_W-1:0] level_wait;
   } vcs_cfg_s;

   localparam vcs_cfg_s CFG_RESET = '0;

   typedef enum logic [3:0] {
      ST_IDLE   = 4'h1,
      ST_SETTLE = 4'h2,
      ST_BAND   = 4'h4,
      ST_LEVEL  = 4'h8
   } vcs_state_e;
endpackage
`default_nettype wire

// ==== hdl/vcs_ref_path.sv ====
// Purpose: reference doubler and divide-by-2 producing the comparison clock
// Assumes: ref_in is synchronous to mclk and well below half its rate
// Notes: the comparison clock is a level plus a one-cycle tick per period
`default_nettype none
module vcs_ref_path (
   input wire logic mclk,
   input wire logic srst,
   input wire logic ref_in,
   input wire logic doubler_en,
   input wire logic halve_en,
   output logic pfd_tick,
   output logic pfd_clk
);
   logic ref_q;
   logic half_q;
   logic next_half_q;
   logic next_pfd_tick;
   logic next_pfd_clk;
   logic rise;
   logic fall;
   logic edge_evt;

   // edge detection; doubling takes both edges, so two events per reference period
   always_comb begin
      rise = ref_in & ~ref_q;
      fall = ~ref_in & ref_q;
      // RL1 - doubler both edges
      edge_evt = doubler_en ? (rise | fall) : rise;
      next_half_q = half_q;
      next_pfd_tick = 1'b0;
      next_pfd_clk = doubler_en ? edge_evt : ref_in;
      if (halve_en) begin
         // RL2 - toggle halves, even duty
         if (edge_evt) begin
            next_half_q = ~half_q;
         end
         next_pfd_tick = edge_evt & ~half_q;
         next_pfd_clk = next_half_q;
      end else begin
         next_pfd_tick = edge_evt;
      end
   end

   // registers only
   always_ff @(posedge mclk) begin
      if (srst) begin
         // seeded from the pin so a high reference at release gives no false edge
         ref_q <= ref_in;
         half_q <= 1'b0;
         pfd_tick <= 1'b0;
         pfd_clk <= 1'b0;
      end else begin
         ref_q <= ref_in;
         half_q <= next_half_q;
         pfd_tick <= next_pfd_tick;
         pfd_clk <= next_pfd_clk;
      end
   end
endmodule
`default_nettype wire

// ==== test/vcs_seq_assertions.sv ====
// Purpose: port checker for the calibration sequencer
// Assumes: one clock domain, synchronous active-high reset
// Notes: exact phase lengths are measured by the bench, not here
`default_nettype none
module vcs_seq_assertions (
   input wire logic mclk,
   input wire logic srst,
   input wire logic ref_in,
   input wire logic doubler_en,
   input wire logic halve_en,
   input wire logic cal_start,
   input wire vcs_pkg::vcs_cfg_s cfg_in,
   input wire logic pfd_clk,
   input wire logic band_clk,
   input wire logic tuning_voltage_hold,
   input wire logic band_select_active,
   input wire logic automatic_level_calibration_active,
   input wire logic cal_busy,
   input wire logic cal_done
);
   default clocking @(posedge mclk); endclocking
   default disable iff (srst);
   // short names for the three phase flags
   wire logic hv = tuning_voltage_hold;
   wire logic bs = band_select_active;
   wire logic lv = automatic_level_calibration_active;
   AST_START_TAKEN: assert property (cal_start && !cal_busy |=> cal_busy && hv)
      else $error("accepted start did not open settle");
   AST_ONE_PHASE: assert property ($onehot0({hv, bs, lv}))
      else $error("two phases at once");
   AST_BUSY_MATCH: assert property (cal_busy == (hv || bs || lv))
      else $error("busy does not match phase flags");
   AST_SETTLE_TO_BAND: assert property ($fell(hv) |-> bs)
      else $error("settle did not hand over to band");
   AST_BAND_AFTER_SETTLE: assert property ($rose(bs) |-> $past(hv))
      else $error("band began without settle");
   AST_BAND_TO_LEVEL: assert property ($fell(bs) |-> lv && $past(bs))
      else $error("band did not hand over to level");
   AST_DONE_PULSE: assert property (cal_done |-> $past(lv) && !lv && !cal_busy ##1 !cal_done)
      else $error("done pulse out of place");
   AST_BAND_CLK_PHASE: assert property (band_clk |-> bs)
      else $error("band clock outside band phase");
   // half a band period is 8N ticks, at least eight, so never under eight cycles
   AST_BAND_CLK_HALF: assert property ($rose(band_clk) |-> band_clk[*8])
      else $error("band clock high too short");
endmodule
bind vcs_sequencer vcs_seq_assertions chk (.mclk, .srst, .ref_in, .doubler_en, .halve_en, .cal_start,
   .cfg_in, .pfd_clk, .band_clk, .tuning_voltage_hold, .band_select_active,
   .automatic_level_calibration_active, .cal_busy, .cal_done);
`default_nettype wire

// ==== test/vcs_sequencer_bench.sv ====
// Purpose: self-checking bench for the calibration sequencer
// Assumes: reference runs at mclk/8, so one tick per 8, 4, 16 or 8 cycles
// Notes: settle start jitters by up to one tick period, later phases are exact
`default_nettype none
module vcs_sequencer_bench;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct {logic d; logic h; vcs_pkg::vcs_cfg_s c; int p;} vcs_row_s;
   logic mclk, srst, doubler_en, halve_en, cal_start, pfd_clk, band_clk, hv, bs, lv, cal_busy, cal_done, pb, pq;
   // the free-running reference source is the only writer of these two
   logic ref_in = 1'h0;
   logic [2:0] rdiv = 3'h0;
   vcs_pkg::vcs_cfg_s cfg_in, cf;
   vcs_row_s rows[4];
   int err_count = 0, n_tests = 0, cyc = 0, n_hv, n_bs, n_lv, n_bc, n_pc, n_pr, k, st, lt;
   vcs_sequencer uut (.mclk, .srst, .ref_in, .doubler_en, .halve_en, .cal_start, .cfg_in, .pfd_clk, .band_clk,
      .tuning_voltage_hold(hv), .band_select_active(bs), .automatic_level_calibration_active(lv), .cal_busy,
      .cal_done);
   initial begin
      mclk = 1'h0;
      forever #50 mclk = ~mclk;
   end
   // reference source and watchdog; a hang lands in the closing report
   always @(posedge mclk) begin
      rdiv <= rdiv + 3'h1;
      ref_in <= rdiv[2];
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         err_count++;
         $display("FAIL %0t watchdog expired", $time);
         stop_test();
      end
   end
   task chk_n(input int got, input int exp, input string what);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("FAIL %0t %s got %0d exp %0d", $time, what, got, exp);
      end
   endtask
   task chk_b(input logic got, input logic exp, input string what);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("FAIL %0t %s", $time, what);
      end
   endtask
   task stop_test();
      $display("tests %0d errors %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // one calibration with a refused restart and cfg change mid-run
   task run(input int p);
      cf = cfg_in;
      st = cf.timeout * cf.lock_timeout;
      lt = 30 * cf.level_wait * cf.timeout;
      n_hv = 0;
      n_bs = 0;
      n_lv = 0;
      n_bc = 0;
      n_pc = 0;
      n_pr = 0;
      k = 0;
      pb = 1'h0;
      pq = 1'h0;
      @(posedge mclk) cal_start <= 1'h1;
      do begin
         @(posedge mclk);
         k++;
         cal_start <= (k == 3);
         if (k == 3) cfg_in <= '1;
         #1;
         n_hv += (hv === 1'h1);
         n_bs += (bs === 1'h1);
         n_lv += (lv === 1'h1);
         n_bc += (band_clk === 1'h1 && pb !== 1'h1);
         pb = band_clk;
         n_pc += (pfd_clk === 1'h1);
         n_pr += (pfd_clk === 1'h1 && pq !== 1'h1);
         pq = pfd_clk;
      end while (cal_done !== 1'h1);
      chk_b(n_hv > ((st == 0 ? 1 : st) - 1) * p && n_hv <= (st == 0 ? 1 : st) * p, 1'h1, "settle");
      chk_n(n_bs, 176 * cf.band_div * p, "band length");
      chk_n(n_bc, 11, "band clock periods");
      chk_n(n_lv, (lt == 0 ? 1 : lt) * p, "level length");
      chk_b(cal_busy, 1'h0, "busy after done");
      // one comparison-clock rise per tick period, give or take the window ends
      chk_b(n_pr * p >= k - p && n_pr * p <= k + 2 * p, 1'h1, "comparison clock rate");
      chk_b(halve_en !== 1'h1 || (2 * n_pc >= k - p && 2 * n_pc <= k + p), 1'h1, "comparison duty");
      @(posedge mclk);
      #1 chk_b(cal_done, 1'h0, "done lasts one cycle");
   endtask
   initial begin
      srst = 1'h1;
      doubler_en = 1'h0;
      halve_en = 1'h0;
      cal_start = 1'h0;
      cfg_in = '0;
      // doubler, halver, counts, expected tick period in cycles
      // band counts keep every band clock under 100 kHz
      rows[0] = '{1'h0, 1'h0, '{10'h002, 5'h03, 8'h01, 5'h01}, 8};
      rows[1] = '{1'h1, 1'h0, '{10'h001, 5'h1F, 8'h02, 5'h1F}, 4};
      rows[2] = '{1'h0, 1'h1, '{10'h007, 5'h02, 8'h01, 5'h05}, 16}; // settle 22.4 us, wait 2.5x
      rows[3] = '{1'h1, 1'h1, '{10'h000, 5'h05, 8'h01, 5'h02}, 8};
      repeat (5) @(posedge mclk);
      srst <= 1'h0;
      @(posedge mclk);
      #1 chk_b(|{hv, bs, lv, cal_busy, cal_done, band_clk}, 1'h0, "idle after reset");
      $display("reset idle test done");
      foreach (rows[i]) begin
         @(posedge mclk);
         doubler_en <= rows[i].d;
         halve_en <= rows[i].h;
         cfg_in <= rows[i].c;
         repeat (20) @(posedge mclk);
         run(rows[i].p);
         $display("row %0d done", i);
      end
      // reset in mid-band, then a clean restart
      @(posedge mclk) cfg_in <= rows[0].c;
      @(posedge mclk) cal_start <= 1'h1;
      @(posedge mclk) cal_start <= 1'h0;
      repeat (100) @(posedge mclk);
      srst <= 1'h1;
      repeat (5) @(posedge mclk);
      #1 chk_b(|{hv, bs, lv, cal_busy, cal_done, band_clk}, 1'h0, "cleared by reset");
      @(posedge mclk) srst <= 1'h0;
      run(8);
      $display("reset test done");
      stop_test();
   end
endmodule
`default_nettype wire
